// [dv/plbc_src_model.sv]
// Behavioural crystal and VCO source at the far side of the loop control block
module plbc_src_model (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic i_run,
   input wire logic [31:0] i_xtal_per,
   input wire logic [31:0] i_vco_per,
   output logic o_crystal_tick,
   output logic o_vco_tick
);
   timeunit 1ns;
   timeprecision 100ps;
   int xc = 0;
   int vc = 0;
   // A crystal without its amplifier does not swing, so its ticks stop
   always @(posedge I_CLK) begin
      xc <= (I_RST || !i_run || xc >= i_xtal_per - 1) ? 0 : xc + 1;
      o_crystal_tick <= !I_RST && i_run && xc == i_xtal_per - 1;
      // A shortened period restarts the count rather than waiting for a wrap
      vc <= (I_RST || vc >= i_vco_per - 1) ? 0 : vc + 1;
      o_vco_tick <= !I_RST && vc == i_vco_per - 1;
   end
endmodule : plbc_src_model

// [dv/test_pll_bandwidth_lock_control.sv]
// Self-checking bench of the loop control block
module test_pll_bandwidth_lock_control;
   timeunit 1ns;
   timeprecision 100ps;
   logic I_CLK = 1'b0;
   logic I_RST = 1'b1;
   logic [7:0] I_ADDR = 8'h00;
   logic [31:0] I_WDATA = 32'h0000_0000;
   logic I_WR = 1'b0;
   logic I_RD = 1'b0;
   logic I_SYSINT_OSCILLATOR_ENABLE = 1'b0;
   logic xt, vt, amp, lref, dref, fb, up, dn, trk, irq;
   logic [31:0] rdata, cfreq;
   logic rd_d = 1'b0;
   logic [31:0] exp_q[$];
   int xper = 20;
   int vper = 5;
   int n_mismatch = 0;
   int cmp_count = 0;
   int p, cu, cd, l, e, r;
   plbc_top i_plbc_top (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
      .I_RD(I_RD), .I_SYSINT_OSCILLATOR_ENABLE(I_SYSINT_OSCILLATOR_ENABLE), .I_CRYSTAL_TICK(xt),
      .I_VCO_TICK(vt), .O_RDATA(rdata), .O_XTAL_AMP_ENABLE(amp), .O_LOOP_REFERENCE_TICK(lref),
      .O_DIVIDED_REFERENCE_TICK(dref), .O_VCO_FEEDBACK_TICK(fb), .O_PUMP_UP(up), .O_PUMP_DOWN(dn),
      .O_TRACKING_MODE(trk), .O_CENTER_FREQ_DHZ(cfreq), .O_IRQ(irq));
   plbc_src_model i_plbc_src_model (.I_CLK(I_CLK), .I_RST(I_RST), .i_run(amp), .i_xtal_per(xper),
      .i_vco_per(vper), .o_crystal_tick(xt), .o_vco_tick(vt));
   initial begin
      forever #10 I_CLK = ~I_CLK;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   // Read data stand only in the cycle after the strobe, so look mid-cycle
   always @(posedge I_CLK) rd_d <= I_RD;
   always @(negedge I_CLK) begin
      if (rd_d) chk(rdata, exp_q.pop_front(), "read data");
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= 1'b1;
      @(posedge I_CLK);
      I_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      exp_q.push_back(x);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_RD <= 1'b1;
      @(posedge I_CLK);
      I_RD <= 1'b0;
   endtask : rd
   function automatic logic pick(input int s);
      case (s)
         0: return lref;
         1: return dref;
         2: return fb;
         3: return trk;
         default: return irq;
      endcase
   endfunction : pick
   // Cycles between two pulses of one output; bounded so a dead output cannot hang
   task automatic period(input int s, output int n);
      int c;
      repeat (2) begin
         c = 0;
         do begin
            @(negedge I_CLK);
            c++;
         end while (!pick(s) && c < 3000);
      end
      n = c;
   endtask : period
   task automatic wait_for(input int s, input logic v);
      int c;
      c = 0;
      while (pick(s) !== v && c < 3000) begin
         @(negedge I_CLK);
         c++;
      end
   endtask : wait_for
   initial begin
      repeat (40000) @(posedge I_CLK);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      void'($urandom(78));
      repeat (4) @(posedge I_CLK);
      I_RST <= 1'b0;
      rd(plbc_pkg::ADDR_CTRL, 32'h0000_0000);
      rd(plbc_pkg::ADDR_BW, 32'h0000_0000);
      rd(plbc_pkg::ADDR_RDIV, 32'h0000_0001);
      rd(plbc_pkg::ADDR_NDIV, 32'h0000_0030);
      rd(plbc_pkg::ADDR_VRS, 32'h0000_0040);
      rd(plbc_pkg::ADDR_STAT, 32'h0000_0000);
      wr(8'h18, 32'hFFFF_FFFF);
      rd(8'h18, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         I_SYSINT_OSCILLATOR_ENABLE <= i[0];
         wr(plbc_pkg::ADDR_CTRL, {29'h0, i[1], 2'h0});
         repeat (2) @(negedge I_CLK);
         chk(amp, i[0] | i[1], "amp enable");
         rd(plbc_pkg::ADDR_STAT, {30'h0, i[0] | i[1], 1'b0});
      end
      repeat (4) begin
         l = $urandom_range(255, 1);
         e = $urandom_range(2, 0);
         wr(plbc_pkg::ADDR_VRS, l);
         wr(plbc_pkg::ADDR_CTRL, e << 8);
         repeat (3) @(negedge I_CLK);
         chk(cfreq, l * (1 << e) * plbc_pkg::FNOM_DHZ, "center");
      end
      r = $urandom_range(4, 1);
      wr(plbc_pkg::ADDR_RDIV, r);
      wr(plbc_pkg::ADDR_NDIV, 32'h0000_0003);
      vper = 3;
      // Tracking select is still clear here, as it must be before power on
      wr(plbc_pkg::ADDR_CTRL, 32'h0000_0022);
      period(0, p);
      chk(p, 20, "reference period");
      period(1, p);
      chk(p, r * 20, "divided period");
      period(2, p);
      chk(p, 36, "feedback period");
      wr(plbc_pkg::ADDR_RDIV, 32'h0000_0001);
      for (int j = 0; j < 2; j++) begin
         vper = j ? 9 : 1;
         repeat (30) @(negedge I_CLK);
         cu = 0;
         cd = 0;
         repeat (600) begin
            @(negedge I_CLK);
            cu += up;
            cd += dn;
         end
         chk(j ? cu > cd : cd > cu, 1, "pump direction");
      end
      xper = 40;
      vper = 10;
      wr(plbc_pkg::ADDR_NDIV, 32'h0000_0004);
      wr(plbc_pkg::ADDR_CTRL, 32'h0000_0003);
      repeat (400) @(negedge I_CLK);
      chk(irq, 0, "manual irq");
      wr(plbc_pkg::ADDR_BW, 32'h0000_0002);
      rd(plbc_pkg::ADDR_BW, 32'h0000_0002);
      chk(trk, 1, "manual tracking");
      wr(plbc_pkg::ADDR_BW, 32'h0000_0000);
      repeat (3) @(negedge I_CLK);
      chk(trk, 0, "acquisition");
      wr(plbc_pkg::ADDR_BW, 32'h0000_0001);
      wait_for(4, 1'b1);
      chk(irq, 1, "lock irq");
      chk(trk, 1, "auto tracking");
      rd(plbc_pkg::ADDR_BW, 32'h0000_0007);
      rd(plbc_pkg::ADDR_STAT, 32'h0000_0007);
      wr(plbc_pkg::ADDR_BW, 32'h0000_0003);
      rd(plbc_pkg::ADDR_BW, 32'h0000_0007);
      wr(plbc_pkg::ADDR_STAT, 32'h0000_0001);
      repeat (3) @(negedge I_CLK);
      chk(irq, 0, "irq cleared");
      vper = 3;
      wait_for(4, 1'b1);
      chk(irq, 1, "unlock irq");
      // Tracking may lag the lock flag by one reference period while the rate changes
      repeat (50) @(negedge I_CLK);
      chk(trk, 0, "lost tracking");
      rd(plbc_pkg::ADDR_BW, 32'h0000_0001);
      // Loss of lock seen: recover by clearing the event and relocking
      wr(plbc_pkg::ADDR_STAT, 32'h0000_0001);
      wr(plbc_pkg::ADDR_CTRL, 32'h0000_0002);
      vper = 10;
      wait_for(3, 1'b1);
      repeat (150) @(negedge I_CLK);
      chk(irq, 0, "masked irq");
      rd(plbc_pkg::ADDR_STAT, 32'h0000_0007);
      wr(plbc_pkg::ADDR_CTRL, 32'h0000_0003);
      repeat (3) @(negedge I_CLK);
      chk(irq, 1, "unmasked irq");
      wr(plbc_pkg::ADDR_BW, 32'h0000_0000);
      repeat (3) @(negedge I_CLK);
      chk(irq, 0, "manual irq");
      rd(plbc_pkg::ADDR_BW, 32'h0000_0000);
      repeat (3) @(posedge I_CLK);
      print_verdict();
   end
endmodule : test_pll_bandwidth_lock_control

// [include/plbc_pkg.sv]
// Package with register map, field positions and constants of the loop control block
package plbc_pkg;
   // Register byte addresses, four bytes apart (32-bit words)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BW = 8'h04;
   localparam logic [7:0] ADDR_RDIV = 8'h08;
   localparam logic [7:0] ADDR_NDIV = 8'h0C;
   localparam logic [7:0] ADDR_VRS = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   // Control register fields
   localparam int CTRL_IRQ_EN = 0;
   localparam int CTRL_PWR_ON = 1;
   localparam int CTRL_OSC_KEEP = 2;
   localparam int CTRL_PRE_LO = 4;
   localparam int CTRL_VPR_LO = 8;
   // Bandwidth register fields
   localparam int BW_AUTO = 0;
   localparam int BW_TRACK = 1;
   localparam int BW_LOCK = 2;
   // Status register fields
   localparam int STAT_LOCK_CHG = 0;
   localparam int STAT_OSC_EN = 1;
   localparam int STAT_TRACK = 2;
   // Field widths
   localparam int RDIV_W = 4;
   localparam int NDIV_W = 12;
   localparam int LIN_W = 8;
   localparam int PRE_W = 2;
   localparam int VPR_W = 2;
   // Reset values
   localparam logic [RDIV_W-1:0] RDIV_RST = 4'h1;
   localparam logic [NDIV_W-1:0] NDIV_RST = 12'h0_030;
   localparam logic [LIN_W-1:0] LIN_RST = 8'h40;
   // Nominal center frequency in Hz, scaled by ten (38.4 kHz)
   localparam int FNOM_DHZ = 384000;
   // Lock tolerance in feedback counts per reference period
   localparam int LOCK_TOL = 1;
   localparam int TRACK_TOL = 2;
endpackage : plbc_pkg

// [rtl/plbc_div.sv]
// Modulo divider producing a one-cycle enable every n input enables
module plbc_div #(
   parameter int W = 12
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic i_en,
   input wire logic [W-1:0] i_mod,
   output logic o_tick
);
   logic [W-1:0] cnt;
   logic [W-1:0] lim;

   // Zero modulo behaves as one
   assign lim = (i_mod == '0) ? W'(1) : i_mod;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         cnt <= '0;
         o_tick <= 1'b0;
      end else begin
         o_tick <= 1'b0;
         if (i_en) begin
            if (cnt >= lim - W'(1)) begin
               cnt <= '0;
               o_tick <= 1'b1;
            end else begin
               cnt <= cnt + W'(1);
            end
         end
      end
   end
endmodule : plbc_div

// [rtl/plbc_top.sv]
// Loop bandwidth, divider and lock control of the on-chip clock generator
// What this block does, and what software must do (RL14 to RL18)
// RL1: Oscillator enabled by system or stop bit
// RL2: Reference clock is buffered crystal clock
// RL3: Reference divided by modulo R
// RL4: VCO divided by two-power P then N
// RL5: Phase compare gives signed correction pulse
// RL6: Frequency compare decides mode and lock
// RL7: Center frequency is L times 2^E times nominal
// RL8: Tracking select clear means acquisition
// RL9: Automatic mode lets detector switch filter
// RL10: Auto mode tracking bit read-only, hardware driven
// RL11: Auto mode lock flag read-only, tolerance driven
// RL12: Lock change requests interrupt when enabled
// RL13: Manual mode tracking bit software written
// RL14: Software keeps tracking clear before power on
// RL15: Software waits acquisition time before tracking
// RL16: Software selects VCO only after lock
// RL17: Software programs R for valid reference
// RL18: Software recovers when lock lost
// RL19: Manual mode lock flag held clear
// RL20: Manual mode raises no interrupts
// RL21: Lock and tracking synchronised before use
module plbc_top #(
   parameter int NDIV_W = plbc_pkg::NDIV_W
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [7:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic I_SYSINT_OSCILLATOR_ENABLE,
   input wire logic I_CRYSTAL_TICK,
   input wire logic I_VCO_TICK,
   output logic [31:0] O_RDATA,
   output logic O_XTAL_AMP_ENABLE,
   output logic O_LOOP_REFERENCE_TICK,
   output logic O_DIVIDED_REFERENCE_TICK,
   output logic O_VCO_FEEDBACK_TICK,
   output logic O_PUMP_UP,
   output logic O_PUMP_DOWN,
   output logic O_TRACKING_MODE,
   output logic [31:0] O_CENTER_FREQ_DHZ,
   output logic O_IRQ
);
   logic irq_en;
   logic pwr_on;
   logic osc_keep;
   logic [plbc_pkg::PRE_W-1:0] pre;
   logic [plbc_pkg::VPR_W-1:0] vpr;
   logic auto_bw;
   logic track_sw;
   logic [plbc_pkg::RDIV_W-1:0] rdiv;
   logic [NDIV_W-1:0] ndiv;
   logic [plbc_pkg::LIN_W-1:0] lin;
   logic lock_chg;
   logic ref_tick;
   logic rdv_tick;
   logic vdv_tick;
   logic [7:0] pre_cnt;
   logic pre_tick;
   logic [7:0] pre_lim;
   logic [15:0] fb_cnt;
   logic lock_raw;
   logic track_raw;
   logic lock_s1;
   logic lock_s2;
   logic track_s1;
   logic track_s2;
   logic lock_q;
   logic wr_ctrl;
   logic wr_bw;
   logic [NDIV_W-1:0] ndiv_eff;
   logic [15:0] fb_err;
   logic [31:0] next_rdata;

   assign wr_ctrl = I_WR && (I_ADDR == plbc_pkg::ADDR_CTRL);
   assign wr_bw = I_WR && (I_ADDR == plbc_pkg::ADDR_BW);

   // Control registers
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         irq_en <= 1'b0;
         pwr_on <= 1'b0;
         osc_keep <= 1'b0;
         pre <= '0;
         vpr <= '0;
      end else if (wr_ctrl) begin
         irq_en <= I_WDATA[plbc_pkg::CTRL_IRQ_EN];
         pwr_on <= I_WDATA[plbc_pkg::CTRL_PWR_ON];
         osc_keep <= I_WDATA[plbc_pkg::CTRL_OSC_KEEP];
         pre <= I_WDATA[plbc_pkg::CTRL_PRE_LO +: plbc_pkg::PRE_W];
         vpr <= I_WDATA[plbc_pkg::CTRL_VPR_LO +: plbc_pkg::VPR_W];
      end
   end

   // Bandwidth register; the tracking bit only takes writes in manual mode
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         auto_bw <= 1'b0;
         track_sw <= 1'b0;
      end else if (wr_bw) begin
         auto_bw <= I_WDATA[plbc_pkg::BW_AUTO];
         if (!auto_bw) begin
            track_sw <= I_WDATA[plbc_pkg::BW_TRACK]; // see RL13
         end
      end
   end

   // Divider registers and the L factor of the center frequency
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         rdiv <= plbc_pkg::RDIV_RST;
         ndiv <= NDIV_W'(plbc_pkg::NDIV_RST);
         lin <= plbc_pkg::LIN_RST;
      end else if (I_WR) begin
         if (I_ADDR == plbc_pkg::ADDR_RDIV) begin
            rdiv <= I_WDATA[plbc_pkg::RDIV_W-1:0];
         end
         if (I_ADDR == plbc_pkg::ADDR_NDIV) begin
            ndiv <= I_WDATA[NDIV_W-1:0];
         end
         if (I_ADDR == plbc_pkg::ADDR_VRS) begin
            lin <= I_WDATA[plbc_pkg::LIN_W-1:0];
         end
      end
   end

   // Oscillator enable and buffered reference
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_XTAL_AMP_ENABLE <= 1'b0;
         ref_tick <= 1'b0;
      end else begin
         O_XTAL_AMP_ENABLE <= I_SYSINT_OSCILLATOR_ENABLE || osc_keep; // see RL1
         ref_tick <= I_CRYSTAL_TICK && (I_SYSINT_OSCILLATOR_ENABLE || osc_keep); // see RL2
      end
   end

   // Reference divider by R
   plbc_div #(.W(plbc_pkg::RDIV_W)) u_rdiv ( // see RL3
      .I_CLK(I_CLK),
      .I_RST(I_RST),
      .i_en(ref_tick && pwr_on),
      .i_mod(rdiv),
      .o_tick(rdv_tick)
   );

   // Prescaler by two to the P
   assign pre_lim = 8'(1) << pre;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         pre_cnt <= '0;
         pre_tick <= 1'b0;
      end else begin
         pre_tick <= 1'b0;
         if (I_VCO_TICK && pwr_on) begin
            if (pre_cnt >= pre_lim - 8'(1)) begin
               pre_cnt <= '0;
               pre_tick <= 1'b1; // see RL4
            end else begin
               pre_cnt <= pre_cnt + 8'(1);
            end
         end
      end
   end

   plbc_div #(.W(NDIV_W)) u_ndiv ( // see RL4
      .I_CLK(I_CLK),
      .I_RST(I_RST),
      .i_en(pre_tick),
      .i_mod(ndiv),
      .o_tick(vdv_tick)
   );

   // Phase detector: an edge raises its side until the other arrives
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_PUMP_UP <= 1'b0;
         O_PUMP_DOWN <= 1'b0;
      end else if (!pwr_on) begin
         O_PUMP_UP <= 1'b0;
         O_PUMP_DOWN <= 1'b0;
      end else begin
         O_PUMP_UP <= (O_PUMP_UP || rdv_tick) && !(O_PUMP_DOWN || vdv_tick) ? 1'b1 : 1'b0; // see RL5
         O_PUMP_DOWN <= (O_PUMP_DOWN || vdv_tick) && !(O_PUMP_UP || rdv_tick) ? 1'b1 : 1'b0; // see RL5
      end
   end

   // Frequency compare: feedback edges per divided reference period, once per divided reference edge
   assign ndiv_eff = ndiv;
   assign fb_err = (fb_cnt > 16'(1)) ? fb_cnt - 16'(1) : 16'(1) - fb_cnt;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         fb_cnt <= '0;
         lock_raw <= 1'b0;
         track_raw <= 1'b0;
      end else if (!pwr_on) begin
         fb_cnt <= '0;
         lock_raw <= 1'b0;
         track_raw <= 1'b0;
      end else if (rdv_tick) begin
         fb_cnt <= vdv_tick ? 16'(1) : '0;
         // One feedback edge per reference period means the frequencies match
         lock_raw <= (fb_cnt == 16'(plbc_pkg::LOCK_TOL)); // see RL6
         track_raw <= (fb_err < 16'(plbc_pkg::TRACK_TOL)); // see RL6
      end else if (vdv_tick && fb_cnt != 16'hFFFF) begin
         fb_cnt <= fb_cnt + 16'(1);
      end
   end

   // Two-stage synchronisers; the first stage feeds only the second
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
         track_s1 <= 1'b0;
         track_s2 <= 1'b0;
      end else begin
         lock_s1 <= lock_raw; // see RL21
         lock_s2 <= lock_s1;
         track_s1 <= track_raw; // see RL21
         track_s2 <= track_s1;
      end
   end

   // Filter mode and lock flag
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_TRACKING_MODE <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         O_TRACKING_MODE <= auto_bw ? track_s2 : track_sw; // see RL8 RL9 RL10
         lock_q <= auto_bw && lock_s2; // see RL11 RL19
      end
   end

   // Sticky lock change event; a new change wins over a clear
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         lock_chg <= 1'b0;
      end else if (auto_bw && (lock_q != (auto_bw && lock_s2))) begin
         lock_chg <= 1'b1; // see RL12
      end else if (I_WR && I_ADDR == plbc_pkg::ADDR_STAT && I_WDATA[plbc_pkg::STAT_LOCK_CHG]) begin
         lock_chg <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= lock_chg && irq_en && auto_bw; // see RL12 RL20
      end
   end

   // Center frequency, in tenths of a hertz
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_CENTER_FREQ_DHZ <= '0;
      end else begin
         O_CENTER_FREQ_DHZ <= 32'((lin * plbc_pkg::FNOM_DHZ) << vpr); // see RL7
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_LOOP_REFERENCE_TICK <= 1'b0;
         O_DIVIDED_REFERENCE_TICK <= 1'b0;
         O_VCO_FEEDBACK_TICK <= 1'b0;
      end else begin
         O_LOOP_REFERENCE_TICK <= ref_tick;
         O_DIVIDED_REFERENCE_TICK <= rdv_tick;
         O_VCO_FEEDBACK_TICK <= vdv_tick;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = '0;
      unique case (I_ADDR)
         plbc_pkg::ADDR_CTRL: begin
            next_rdata[plbc_pkg::CTRL_IRQ_EN] = irq_en;
            next_rdata[plbc_pkg::CTRL_PWR_ON] = pwr_on;
            next_rdata[plbc_pkg::CTRL_OSC_KEEP] = osc_keep;
            next_rdata[plbc_pkg::CTRL_PRE_LO +: plbc_pkg::PRE_W] = pre;
            next_rdata[plbc_pkg::CTRL_VPR_LO +: plbc_pkg::VPR_W] = vpr;
         end
         plbc_pkg::ADDR_BW: begin
            next_rdata[plbc_pkg::BW_AUTO] = auto_bw;
            next_rdata[plbc_pkg::BW_TRACK] = O_TRACKING_MODE; // see RL10
            next_rdata[plbc_pkg::BW_LOCK] = lock_q; // see RL11
         end
         plbc_pkg::ADDR_RDIV: next_rdata[plbc_pkg::RDIV_W-1:0] = rdiv;
         plbc_pkg::ADDR_NDIV: next_rdata[NDIV_W-1:0] = ndiv_eff;
         plbc_pkg::ADDR_VRS: next_rdata[plbc_pkg::LIN_W-1:0] = lin;
         plbc_pkg::ADDR_STAT: begin
            next_rdata[plbc_pkg::STAT_LOCK_CHG] = lock_chg;
            next_rdata[plbc_pkg::STAT_OSC_EN] = O_XTAL_AMP_ENABLE;
            next_rdata[plbc_pkg::STAT_TRACK] = O_TRACKING_MODE;
         end
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_RDATA <= '0;
      end else begin
         O_RDATA <= I_RD ? next_rdata : '0;
      end
   end

   osc_enable_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL1
      O_XTAL_AMP_ENABLE == $past(I_SYSINT_OSCILLATOR_ENABLE || osc_keep))
      else $error("oscillator enable wrong");
   ref_copy_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL2
      ref_tick |-> $past(I_CRYSTAL_TICK)) else $error("reference tick without crystal tick");
   ref_div_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL3
      rdv_tick |-> $past(ref_tick && pwr_on)) else $error("reference divider tick without reference");
   pump_excl_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL5
      !(O_PUMP_UP && O_PUMP_DOWN)) else $error("pump both ways");
   manual_track_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL13
      !auto_bw && $stable(auto_bw) && $stable(track_sw) |=> O_TRACKING_MODE == $past(track_sw))
      else $error("manual tracking mismatch");
   auto_ro_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL10
      auto_bw && wr_bw |=> $stable(track_sw)) else $error("tracking bit written in auto");
   manual_lock_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL19
      !$past(auto_bw) |-> !lock_q) else $error("lock flag in manual mode");
   manual_irq_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL20
      !$past(auto_bw) |-> !O_IRQ) else $error("interrupt in manual mode");
   lock_sync_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL21
      $rose(lock_q) |-> $past(lock_raw, 3)) else $error("lock not synchronised");
   // A change seen together with a software clear must still be kept
   chg_set_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL12
      auto_bw && (lock_q != lock_s2) |=> lock_chg) else $error("lock change event lost");
   auto_track_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL10
      auto_bw |=> O_TRACKING_MODE == $past(track_s2)) else $error("auto tracking not from detector");
   lock_auto_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL11
      auto_bw |=> lock_q == $past(lock_s2)) else $error("lock flag not from detector");
   pump_off_a: assert property (@(posedge I_CLK) disable iff (I_RST) // see RL5
      !pwr_on |=> !O_PUMP_UP && !O_PUMP_DOWN) else $error("pump while loop off");
   rdata_idle_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !I_RD |=> O_RDATA == '0) else $error("read data outside read");
endmodule : plbc_top
